// *** wdfc_pkg.sv ***
// Constants and carrier types for the watchdog feed and control block.
// Assumes a single 25 MHz clock domain; the core writes registers by address strobe.
//
// Overview of operation
// - A completed feed copies staged control to shadow and reload to the down counter.
// - In watchdog mode staged control and reload writes have no effect until a feed completes.
// - Feed is A5 to first feed register then 5A to second, only that order.
// - Reads allowed between feed writes; any other register write breaks the feed.
// - In watchdog mode a broken feed asserts watchdog reset immediately.
// - In watchdog mode a control write not followed by a feed causes reset.
// - In timer mode staged control copies into the shadow every cycle.
// - In timer mode the reload value reaches the counter through a feed or an underflow.
// - Run control bit 2 starts counting when 1, stops when 0.
// - With both enables set, run control is forced to 1.
// - Time-out flag bit 1 sets on down counter underflow.
// - Feed in watchdog mode clears time-out flag except in an underflow cycle; writing 0 clears it unless both enables are set and a feed has locked writes.
// - Clock select 1 picks watchdog oscillator, 0 peripheral clock; forced 1 with both enables.
// - Time-out is 2^(5+tap) times (reload+1) plus one watchdog clocks.
// - Underflow with reset on underflow enabled asserts watchdog reset.
// - In timer mode underflow reloads the counter and may raise an interrupt.
package wdfc_pkg;

	localparam logic [7:0] WDFC_ADDR_CONTROL = 8'hA7;
	localparam logic [7:0] WDFC_ADDR_RELOAD = 8'hC1;
	localparam logic [7:0] WDFC_ADDR_FEED1 = 8'hC2;
	localparam logic [7:0] WDFC_ADDR_FEED2 = 8'hC3;

	localparam logic [7:0] WDFC_FEED1_VAL = 8'hA5;
	localparam logic [7:0] WDFC_FEED2_VAL = 8'h5A;

	localparam int WDFC_TAP_LSB = 5;
	localparam int WDFC_RUN_BIT = 2;
	localparam int WDFC_TOF_BIT = 1;
	localparam int WDFC_CLK_BIT = 0;
	localparam logic [7:0] WDFC_CTRL_WMASK = 8'hE7;

	localparam logic [7:0] WDFC_CONTROL_RESET = 8'hE5;
	localparam logic [7:0] WDFC_RELOAD_RESET = 8'hFF;
	localparam int WDFC_PRESCALE_BASE = 5;
	localparam int WDFC_PRESCALE_WIDTH = 13;

	typedef enum logic [1:0] {
		WDFC_FEED_IDLE = 2'b00,
		WDFC_FEED_ARMED = 2'b01,
		WDFC_FEED_NEED = 2'b11
	} wdfc_feed_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} wdfc_bus_t;

	typedef struct packed {
		logic [7:0] staged_ctrl;
		logic [7:0] shadow_ctrl;
		logic [7:0] reload;
		logic [7:0] count;
		logic [WDFC_PRESCALE_WIDTH-1:0] prescale;
		logic [1:0] osc_sync;
		logic osc_prev;
		logic tick_pending;
		wdfc_feed_t feed;
		logic ctrl_written;
		logic locked;
		logic wd_reset;
		logic irq;
		logic [7:0] rdata;
	} wdfc_state_t;

endpackage : wdfc_pkg

// *** wdfc_watchdog.sv ***
// Watchdog feed recogniser, staged/shadow control, prescaler and down counter.
// Assumes the core issues one-cycle write strobes; osc is an asynchronous oscillator pin.
`timescale 1ns/1ps
module wdfc_watchdog
(
	input wire logic clk,
	input wire logic rst,
	input wire wdfc_pkg::wdfc_bus_t bus,
	input wire logic osc,
	input wire logic reset_on_underflow_enable,
	input wire logic safety_enable,
	input wire logic watchdog_irq_enable,
	output logic [7:0] rdata,
	output logic wd_reset,
	output logic irq,
	output logic [7:0] active_ctrl
);

	wdfc_pkg::wdfc_state_t s_r;
	wdfc_pkg::wdfc_state_t s_nxt;

	logic force_safe;
	logic wd_mode;
	logic feed_ok;
	logic feed_bad;
	logic wr_ctrl;
	logic wr_reload;
	logic wr_f1;
	logic wr_f2;
	logic wclk_en;
	logic tap_hit;
	logic [2:0] tap;
	logic [3:0] tap_pos;
	logic [wdfc_pkg::WDFC_PRESCALE_WIDTH-1:0] tap_mask;
	logic underflow;
	logic [7:0] ctrl_w;

	assign force_safe = reset_on_underflow_enable & safety_enable;
	assign wd_mode = reset_on_underflow_enable;
	assign wr_ctrl = bus.wr && bus.addr == wdfc_pkg::WDFC_ADDR_CONTROL;
	assign wr_reload = bus.wr && bus.addr == wdfc_pkg::WDFC_ADDR_RELOAD;
	assign wr_f1 = bus.wr && bus.addr == wdfc_pkg::WDFC_ADDR_FEED1;
	assign wr_f2 = bus.wr && bus.addr == wdfc_pkg::WDFC_ADDR_FEED2;

	always_comb
	begin
		s_nxt = s_r;
		feed_ok = 1'b0;
		feed_bad = 1'b0;
		ctrl_w = (bus.wdata & wdfc_pkg::WDFC_CTRL_WMASK);

		// Oscillator pin synchroniser and edge detect
		s_nxt.osc_sync = {s_r.osc_sync[0], osc};
		s_nxt.osc_prev = s_r.osc_sync[1];
		// Watchdog clock enable: oscillator edge or every peripheral cycle
		if (s_r.shadow_ctrl[wdfc_pkg::WDFC_CLK_BIT])
			wclk_en = s_r.osc_sync[1] & ~s_r.osc_prev;
		else
			wclk_en = 1'b1;

		// Feed recogniser
		case (s_r.feed)
			wdfc_pkg::WDFC_FEED_IDLE:
			begin
				if (wr_f1 && bus.wdata == wdfc_pkg::WDFC_FEED1_VAL)
					s_nxt.feed = wdfc_pkg::WDFC_FEED_ARMED;
				else if (wr_f1 || wr_f2)
					feed_bad = 1'b1;
			end
			wdfc_pkg::WDFC_FEED_ARMED:
			begin
				if (wr_f2 && bus.wdata == wdfc_pkg::WDFC_FEED2_VAL)
				begin
					feed_ok = 1'b1;
					s_nxt.feed = wdfc_pkg::WDFC_FEED_IDLE;
				end
				else if (bus.wr)
				begin
					feed_bad = 1'b1;
					s_nxt.feed = wdfc_pkg::WDFC_FEED_IDLE;
				end
			end
			default:
				s_nxt.feed = wdfc_pkg::WDFC_FEED_IDLE;
		endcase

		// Control write must be followed at once by a feed in watchdog mode
		if (s_r.ctrl_written && bus.wr && !wr_f1)
			feed_bad = 1'b1;
		if (wr_ctrl)
			s_nxt.ctrl_written = wd_mode;
		else if (bus.wr || feed_bad)
			s_nxt.ctrl_written = 1'b0;

		// Staged registers; in watchdog mode writes touch only these until a feed
		if (wr_ctrl && !(force_safe && s_r.locked))
		begin
			s_nxt.staged_ctrl = ctrl_w;
			if (force_safe)
			begin
				s_nxt.staged_ctrl[wdfc_pkg::WDFC_RUN_BIT] = 1'b1;
				s_nxt.staged_ctrl[wdfc_pkg::WDFC_CLK_BIT] = 1'b1;
			end
			// Flag may only be cleared by software
			s_nxt.staged_ctrl[wdfc_pkg::WDFC_TOF_BIT] =
				s_r.shadow_ctrl[wdfc_pkg::WDFC_TOF_BIT] & ctrl_w[wdfc_pkg::WDFC_TOF_BIT];
		end
		if (wr_reload && !(force_safe && s_r.locked))
			s_nxt.reload = bus.wdata;

		// Prescaler and down counter
		tap = s_r.shadow_ctrl[wdfc_pkg::WDFC_TAP_LSB +: 3];
		// Low prescaler bits that must all be set for one counter tick
		tap_pos = 4'(wdfc_pkg::WDFC_PRESCALE_BASE) + 4'(tap);
		tap_mask = ~({wdfc_pkg::WDFC_PRESCALE_WIDTH{1'b1}} << tap_pos);
		tap_hit = 1'b0;
		underflow = 1'b0;
		if (s_r.shadow_ctrl[wdfc_pkg::WDFC_RUN_BIT] && wclk_en)
		begin
			if (s_r.tick_pending)
			begin
				// Final extra clock after the count reaches the end
				s_nxt.tick_pending = 1'b0;
				underflow = 1'b1;
			end
			else
			begin
				s_nxt.prescale = s_r.prescale + 1'b1;
				tap_hit = (s_r.prescale & tap_mask) == tap_mask;
			end
		end
		if (tap_hit)
		begin
			s_nxt.prescale = '0;
			if (s_r.count == 8'h00)
				s_nxt.tick_pending = 1'b1;
			else
				s_nxt.count = s_r.count - 8'h01;
		end

		// Shadow control update
		if (!wd_mode)
			s_nxt.shadow_ctrl = s_nxt.staged_ctrl;
		s_nxt.irq = 1'b0;
		s_nxt.wd_reset = 1'b0;
		if (underflow)
		begin
			s_nxt.shadow_ctrl[wdfc_pkg::WDFC_TOF_BIT] = 1'b1;
			s_nxt.staged_ctrl[wdfc_pkg::WDFC_TOF_BIT] = 1'b1;
			s_nxt.prescale = '0;
			if (wd_mode)
				s_nxt.wd_reset = 1'b1;
			else
			begin
				s_nxt.count = s_r.reload;
				s_nxt.irq = watchdog_irq_enable;
			end
		end
		if (feed_ok)
		begin
			s_nxt.count = s_nxt.reload;
			s_nxt.prescale = '0;
			s_nxt.tick_pending = 1'b0;
			s_nxt.shadow_ctrl = s_nxt.staged_ctrl;
			s_nxt.locked = 1'b1;
			if (wd_mode && !underflow)
			begin
				s_nxt.shadow_ctrl[wdfc_pkg::WDFC_TOF_BIT] = 1'b0;
				s_nxt.staged_ctrl[wdfc_pkg::WDFC_TOF_BIT] = 1'b0;
			end
		end
		if (force_safe)
		begin
			s_nxt.shadow_ctrl[wdfc_pkg::WDFC_RUN_BIT] = 1'b1;
			s_nxt.shadow_ctrl[wdfc_pkg::WDFC_CLK_BIT] = 1'b1;
		end
		if (feed_bad && wd_mode)
			s_nxt.wd_reset = 1'b1;

		// Read data for the core
		case (bus.addr)
			wdfc_pkg::WDFC_ADDR_CONTROL: s_nxt.rdata = s_nxt.staged_ctrl;
			wdfc_pkg::WDFC_ADDR_RELOAD: s_nxt.rdata = s_nxt.reload;
			default: s_nxt.rdata = 8'h00;
		endcase
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			s_r <= '0;
			s_r.staged_ctrl <= wdfc_pkg::WDFC_CONTROL_RESET;
			s_r.shadow_ctrl <= wdfc_pkg::WDFC_CONTROL_RESET;
			s_r.reload <= wdfc_pkg::WDFC_RELOAD_RESET;
			s_r.count <= wdfc_pkg::WDFC_RELOAD_RESET;
			s_r.feed <= wdfc_pkg::WDFC_FEED_IDLE;
		end
		else
			s_r <= s_nxt;
	end

	assign rdata = s_r.rdata;
	assign wd_reset = s_r.wd_reset;
	assign irq = s_r.irq;
	assign active_ctrl = s_r.shadow_ctrl;

endmodule : wdfc_watchdog

// *** wdfc_watchdog_sva.sv ***
// Assertion checker for the watchdog feed and control block.
// Sees only the top module ports; bound in below.
`timescale 1ns/1ps
module wdfc_watchdog_sva
(
	input wire logic clk,
	input wire logic rst,
	input wire wdfc_pkg::wdfc_bus_t bus,
	input wire logic osc,
	input wire logic reset_on_underflow_enable,
	input wire logic safety_enable,
	input wire logic watchdog_irq_enable,
	input wire logic [7:0] rdata,
	input wire logic wd_reset,
	input wire logic irq,
	input wire logic [7:0] active_ctrl
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire logic wm = reset_on_underflow_enable;
	wire logic f1 = bus.wr && bus.addr == wdfc_pkg::WDFC_ADDR_FEED1;
	wire logic f2 = bus.wr && bus.addr == wdfc_pkg::WDFC_ADDR_FEED2;
	wire logic cw = bus.wr && bus.addr == wdfc_pkg::WDFC_ADDR_CONTROL;
	sequence first_ok; wm && f1 && bus.wdata == 8'hA5; endsequence
	sequence pair_ok; first_ok ##1 !bus.wr ##1 f2 && bus.wdata == 8'h5A; endsequence
	good_feed_a: assert property (pair_ok |=> !wd_reset) else $error("good feed reset");
	gap_write_a: assert property (first_ok ##1 !bus.wr ##1 bus.wr && !f2 |=> wd_reset)
		else $error("gap write kept");
	bad_value_a: assert property (wm && f1 && bus.wdata != 8'hA5 |=> wd_reset)
		else $error("bad feed kept");
	ctrl_follow_a: assert property (wm && !safety_enable && cw ##2 bus.wr && !f1 |=> wd_reset)
		else $error("unfed control kept");
	timer_copy_a: assert property (!wm && cw ##1 !wm |=>
		(active_ctrl & 8'hE5) == ($past(bus.wdata, 2) & 8'hE5)) else $error("no timer copy");
	wd_hold_a: assert property ($changed(active_ctrl & 8'hE5) && $past(wm) |->
		$past(f2) || $past(f2, 2)) else $error("shadow moved");
	forced_bits_a: assert property (wm && safety_enable && $past(wm && safety_enable) |->
		active_ctrl[2] && active_ctrl[0]) else $error("bits not forced");
	irq_cause_a: assert property (irq |-> $past(!wm && watchdog_irq_enable))
		else $error("stray irq");
endmodule : wdfc_watchdog_sva
bind wdfc_watchdog wdfc_watchdog_sva wdfc_watchdog_sva_i (.clk, .rst, .bus, .osc,
	.reset_on_underflow_enable, .safety_enable, .watchdog_irq_enable, .rdata, .wd_reset,
	.irq, .active_ctrl);

// *** wdfc_core.sv ***
// Core model: one-cycle register write and read strobes.
// Assumes inputs change at the falling edge of clk.
`timescale 1ns/1ps
module wdfc_core
(
	input wire logic clk,
	output wdfc_pkg::wdfc_bus_t bus
);
	initial bus = '0;
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		bus.addr <= a;
		bus.wdata <= (a == wdfc_pkg::WDFC_ADDR_CONTROL) ? (d & 8'hE7) : d;
		bus.wr <= 1'b1;
		@(negedge clk);
		bus.wr <= 1'b0;
		bus.rd <= 1'b0;
		bus.addr <= ~a;
		bus.wdata <= ~d;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(negedge clk);
		bus.addr <= a;
		bus.rd <= 1'b1;
		@(negedge clk);
		bus.rd <= 1'b0;
	endtask : rd
	task automatic feed;
		wr(wdfc_pkg::WDFC_ADDR_FEED1, 8'hA5);
		wr(wdfc_pkg::WDFC_ADDR_FEED2, 8'h5A);
	endtask : feed
endmodule : wdfc_core

// *** tb.sv ***
// Bench for the watchdog feed and control block.
// Needs the core model and the bound checker.
`timescale 1ns/1ps
module tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic osc = 1'b0;
	logic reset_on_underflow_enable = 1'b1;
	logic safety_enable = 1'b0;
	logic watchdog_irq_enable = 1'b1;
	wdfc_pkg::wdfc_bus_t bus;
	logic [7:0] rdata, active_ctrl;
	logic wd_reset, irq;
	int num_errors = 0, n_tests = 0, n = 0;
	logic [1:0] exp_q[$];
	initial forever #20 clk = ~clk;
	always @(negedge clk) osc <= 1'($urandom);
	wdfc_core wdfc_core_i (.clk, .bus);
	wdfc_watchdog wdfc_watchdog_i (.clk, .rst, .bus, .osc, .reset_on_underflow_enable,
		.safety_enable, .watchdog_irq_enable, .rdata, .wd_reset, .irq, .active_ctrl);
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		n_tests++;
		if (seen !== want)
		begin
			num_errors++;
			$display("MISMATCH %0t got %h exp %h", $time, seen, want);
		end
	endtask : check
	task automatic conclude;
		$display("checks %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : conclude
	task automatic restart(input logic m, input logic s);
		$display("test done %0t", $time);
		rst = 1'b1;
		reset_on_underflow_enable = m;
		safety_enable = s;
		repeat (3) @(negedge clk);
		rst = 1'b0;
		check(active_ctrl, wdfc_pkg::WDFC_CONTROL_RESET);
	endtask : restart
	task automatic await;
		n = 0;
		while (!(wd_reset || irq) && n < 300)
		begin
			@(negedge clk);
			n++;
		end
		check(8'(n >= 300), 8'h00);
		@(negedge clk);
	endtask : await
	always @(negedge clk)
		if (!rst && (wd_reset || irq))
			check({6'h00, wd_reset, irq}, {6'h00, exp_q.size() > 0 ? exp_q.pop_front() : 2'b00});
	initial
	begin
		#(40 * 3000);
		num_errors++;
		conclude();
	end
	initial
	begin
		void'($urandom(32'hE4EDA5B4));
		restart(1'b1, 1'b0);
		wdfc_core_i.wr(wdfc_pkg::WDFC_ADDR_RELOAD, 8'h00);
		wdfc_core_i.wr(wdfc_pkg::WDFC_ADDR_CONTROL, 8'h04);
		check(active_ctrl, wdfc_pkg::WDFC_CONTROL_RESET);
		wdfc_core_i.feed();
		@(negedge clk);
		check(active_ctrl, 8'h04);
		exp_q.push_back(2'b10);
		await();
		check(8'(n), 8'h20);
		restart(1'b1, 1'b0);
		exp_q.push_back(2'b10);
		wdfc_core_i.wr(wdfc_pkg::WDFC_ADDR_FEED1, 8'($urandom) & 8'hFE);
		await();
		check(8'(n < 2), 8'h01);
		restart(1'b1, 1'b0);
		exp_q.push_back(2'b10);
		wdfc_core_i.wr(wdfc_pkg::WDFC_ADDR_FEED1, 8'hA5);
		wdfc_core_i.wr(wdfc_pkg::WDFC_ADDR_RELOAD, 8'h00);
		await();
		check(8'(n < 2), 8'h01);
		wdfc_core_i.wr(wdfc_pkg::WDFC_ADDR_FEED1, 8'hA5);
		wdfc_core_i.rd(wdfc_pkg::WDFC_ADDR_CONTROL);
		check(rdata, wdfc_pkg::WDFC_CONTROL_RESET);
		wdfc_core_i.wr(wdfc_pkg::WDFC_ADDR_FEED2, 8'h5A);
		repeat (4) @(negedge clk);
		restart(1'b1, 1'b0);
		exp_q.push_back(2'b10);
		wdfc_core_i.wr(wdfc_pkg::WDFC_ADDR_CONTROL, 8'hE5);
		wdfc_core_i.wr(wdfc_pkg::WDFC_ADDR_RELOAD, 8'h00);
		await();
		check(8'(n < 2), 8'h01);
		restart(1'b0, 1'b0);
		wdfc_core_i.wr(wdfc_pkg::WDFC_ADDR_CONTROL, 8'h04);
		@(negedge clk);
		check(active_ctrl, 8'h04);
		wdfc_core_i.wr(wdfc_pkg::WDFC_ADDR_FEED1, 8'h00);
		wdfc_core_i.wr(wdfc_pkg::WDFC_ADDR_RELOAD, 8'h00);
		exp_q.push_back(2'b01);
		wdfc_core_i.feed();
		await();
		check(8'(n), 8'h21);
		check(8'(active_ctrl[1]), 8'h01);
		wdfc_core_i.wr(wdfc_pkg::WDFC_ADDR_CONTROL, 8'h00);
		@(negedge clk);
		check(active_ctrl, 8'h00);
		repeat (80) @(negedge clk);
		restart(1'b1, 1'b1);
		wdfc_core_i.wr(wdfc_pkg::WDFC_ADDR_CONTROL, 8'h00);
		wdfc_core_i.feed();
		@(negedge clk);
		check(active_ctrl, 8'h05);
		check(8'(exp_q.size()), 8'h00);
		conclude();
	end
endmodule : tb
